/* File: scb_target.sv */
// Serial bus target with enable and strap readback registers.
//
// Summary of operation
// - Block write: acknowledge address, start index and byte count in turn.
// - Data bytes fill indices N to N+X-1 in turn; each acknowledged.
// - Read: ack write address and index, restart, then ack read address.
// - After read address, count byte first, then registers from the index.
// - Target address chosen by two three-level straps from nine entries.
// - Status bits 7..6 return the latched PLL mode strap; writes ignored.
// - Status bit 0 reads frequency strap: 0 is 133MHz, 1 is 100MHz.
// - Enable bits default one; zero forces pair low; bytes 1, 2 cover 0..15.
// - Status bits 5..3 enable pairs 18..16; bits 2..1 reserved.
// - Writable read count is sent as the block read count byte; default eight.
`timescale 1ns/1ps
`default_nettype none
module scb_target
  import scb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Serial bus pins; the data pin is open drain.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  // Straps, captured once after reset.
  input  wire logic [3:0]  bus_address_straps,
  input  wire logic [1:0]  pll_bandwidth_strap,
  input  wire logic        freq_select_strap,
  // Enables of the clock output pairs.
  output var  logic [18:0] output_pair_enable
);

  logic [8:0]    pins_lvl;
  logic          s_scl;
  logic          s_sda;
  logic          scl_q_r;
  logic          sda_q_r;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  scb_state_type state_r,  state_nxt;
  scb_phase_type phase_r,  phase_nxt;
  logic [2:0]    bit_cnt_r, bit_cnt_nxt;
  logic [7:0]    shift_r,  shift_nxt;
  logic [7:0]    index_r,  index_nxt;
  logic          rw_r,     rw_nxt;
  logic          oe_nxt;
  logic [7:0]    rx_byte;
  logic          byte_done;
  logic          reg_wr;
  logic          addr_hit;
  logic [7:0]    tx_byte;
  logic [2:0]    settle_cnt_r;
  logic          latched_r;
  logic [7:0]    dev_addr_r;
  logic [1:0]    pll_mode_r;
  logic          freq_r;
  logic [7:0]    en_low_r;
  logic [7:0]    en_high_r;
  logic [2:0]    en_top_r;
  logic [4:0]    read_count_r;

  // Pins pass the three-stage sampler before any logic sees them.
  scb_pin_sampler #(.W(9), .RST_VAL(9'h1FF)) u_sampler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({pll_bandwidth_strap, freq_select_strap, bus_address_straps,
               scl_in, sda_in}),
    .level   (pins_lvl)
  );

  // Maps a strap code onto a level: 0 low, 1 mid, 2 high.
  function automatic logic [1:0] strap_level(input logic [1:0] code);
    strap_level = code[1] ? 2'h2 : (code[0] ? 2'h1 : 2'h0);
  endfunction : strap_level

  // Looks up the write-address byte for the two strap codes.
  function automatic logic [7:0] addr_lookup(input logic [3:0] codes);
    logic [3:0] lv;
    lv = {strap_level(codes[3:2]), strap_level(codes[1:0])};
    unique case (lv)
      4'h0:    addr_lookup = SCB_ADDR_LL;
      4'h1:    addr_lookup = SCB_ADDR_LM;
      4'h2:    addr_lookup = SCB_ADDR_LH;
      4'h4:    addr_lookup = SCB_ADDR_ML;
      4'h5:    addr_lookup = SCB_ADDR_MM;
      4'h6:    addr_lookup = SCB_ADDR_MH;
      4'h8:    addr_lookup = SCB_ADDR_HL;
      4'h9:    addr_lookup = SCB_ADDR_HM;
      default: addr_lookup = SCB_ADDR_HH;
    endcase
  endfunction : addr_lookup

  // Maps the bandwidth strap onto its mode readback code.
  function automatic logic [1:0] mode_lookup(input logic [1:0] code);
    unique case (strap_level(code))
      2'h0:    mode_lookup = SCB_MODE_LOW_BW;
      2'h1:    mode_lookup = SCB_MODE_BYPASS;
      default: mode_lookup = SCB_MODE_HIGH_BW;
    endcase
  endfunction : mode_lookup

  // Register readback; unmapped indices read zero.
  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                          input logic [1:0] mode,
                                          input logic [2:0] top,
                                          input logic       freq,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic [4:0] cnt);
    unique case (idx)
      SCB_IDX_PLL_MODE_FREQ_STATUS: reg_read = {mode, top, 2'h0, freq};
      SCB_IDX_OUTPUT_ENABLE_LOW:    reg_read = lo;
      SCB_IDX_OUTPUT_ENABLE_HIGH:   reg_read = hi;
      SCB_IDX_READ_COUNT:           reg_read = {3'h0, cnt};
      default:                      reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Edge and bus condition detection on the sampled pins.
  assign s_scl     = pins_lvl[1];
  assign s_sda     = pins_lvl[0];
  assign scl_rise  = s_scl & ~scl_q_r;
  assign scl_fall  = ~s_scl & scl_q_r;
  assign start_det = s_scl & scl_q_r & sda_q_r & ~s_sda;
  assign stop_det  = s_scl & scl_q_r & ~sda_q_r & s_sda;

  // Byte assembly, address compare and register write strobe.
  assign rx_byte   = {shift_r[6:0], s_sda};
  assign byte_done = (state_r == ST_RX) && scl_rise && (bit_cnt_r == 3'h7);
  assign addr_hit  = latched_r && (rx_byte[7:1] == dev_addr_r[7:1]);
  assign reg_wr    = byte_done && (phase_r == PH_DATA);
  assign tx_byte   = (phase_r == PH_TX_COUNT) ? {3'h0, read_count_r}
                   : reg_read(index_r, pll_mode_r, en_top_r, freq_r,
                              en_low_r, en_high_r, read_count_r);

  // Protocol engine: bits are taken on rising and driven on falling clock.
  always_comb begin
    state_nxt   = state_r;
    phase_nxt   = phase_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    index_nxt   = index_r;
    rw_nxt      = rw_r;
    oe_nxt      = sda_oe;
    if (start_det) begin
      state_nxt   = ST_RX;
      phase_nxt   = PH_ADDR;
      bit_cnt_nxt = 3'h0;
      oe_nxt      = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: ;
        ST_RX: if (scl_rise) begin
          shift_nxt   = rx_byte;
          bit_cnt_nxt = bit_cnt_r + 3'h1;
          if (bit_cnt_r == 3'h7) begin
            state_nxt = ST_ACK_PEND;
            unique case (phase_r)
              PH_ADDR: begin
                rw_nxt    = rx_byte[0];
                phase_nxt = rx_byte[0] ? PH_TX_COUNT : PH_INDEX;
                if (!addr_hit) state_nxt = ST_IDLE;
              end
              PH_INDEX: begin
                index_nxt = rx_byte;
                phase_nxt = PH_COUNT;
              end
              PH_COUNT: phase_nxt = PH_DATA;
              PH_DATA:  index_nxt = index_r + 8'h01;
              default:  state_nxt = ST_IDLE;
            endcase
          end
        end
        ST_ACK_PEND: if (scl_fall) begin
          oe_nxt    = 1'b1;
          state_nxt = ST_ACK_DRV;
        end
        ST_ACK_DRV, ST_TX_NEXT: if (scl_fall) begin
          if (rw_r) begin
            shift_nxt   = tx_byte;
            oe_nxt      = ~tx_byte[7];
            bit_cnt_nxt = 3'h0;
            state_nxt   = ST_TX;
            phase_nxt   = PH_TX_DATA;
            if (phase_r == PH_TX_DATA) index_nxt = index_r + 8'h01;
          end else begin
            oe_nxt      = 1'b0;
            bit_cnt_nxt = 3'h0;
            state_nxt   = ST_RX;
          end
        end
        ST_TX: if (scl_fall) begin
          bit_cnt_nxt = bit_cnt_r + 3'h1;
          if (bit_cnt_r == 3'h7) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_TX_ACK;
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            oe_nxt    = ~shift_r[6];
          end
        end
        ST_TX_ACK: if (scl_rise) begin
          state_nxt = s_sda ? ST_IDLE : ST_TX_NEXT;
        end
      endcase
    end
  end

  // Engine state, edge history and the open-drain drive.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      phase_r   <= PH_ADDR;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      index_r   <= 8'h00;
      rw_r      <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      phase_r   <= phase_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      index_r   <= index_nxt;
      rw_r      <= rw_nxt;
      sda_oe    <= oe_nxt;
      sda_out   <= 1'b0;
      scl_q_r   <= s_scl;
      sda_q_r   <= s_sda;
    end
  end

  // Straps are captured once the sampler has settled after reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt_r <= 3'h0;
      latched_r    <= 1'b0;
      dev_addr_r   <= 8'h00;
      pll_mode_r   <= 2'h0;
      freq_r       <= 1'b0;
    end else if (!latched_r) begin
      settle_cnt_r <= settle_cnt_r + 3'h1;
      if (settle_cnt_r == SCB_STRAP_SETTLE_CYC) begin
        latched_r  <= 1'b1;
        dev_addr_r <= addr_lookup(pins_lvl[5:2]);
        pll_mode_r <= mode_lookup(pins_lvl[8:7]);
        freq_r     <= pins_lvl[6];
      end
    end
  end

  // Writable registers; strap readback bits ignore writes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_low_r     <= SCB_RST_ENABLE_BYTE;
      en_high_r    <= SCB_RST_ENABLE_BYTE;
      en_top_r     <= SCB_RST_TOP_ENABLE;
      read_count_r <= SCB_RST_READ_COUNT;
    end else if (reg_wr) begin
      unique case (index_r)
        SCB_IDX_PLL_MODE_FREQ_STATUS:
          en_top_r <= rx_byte[SCB_POS_TOP_EN_LSB +: 3];
        SCB_IDX_OUTPUT_ENABLE_LOW:  en_low_r     <= rx_byte;
        SCB_IDX_OUTPUT_ENABLE_HIGH: en_high_r    <= rx_byte;
        SCB_IDX_READ_COUNT:         read_count_r <= rx_byte[4:0];
        default: ;
      endcase
    end
  end

  // Pair enables leave through their own flip-flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_pair_enable <= {SCB_RST_TOP_ENABLE, SCB_RST_ENABLE_BYTE,
                             SCB_RST_ENABLE_BYTE};
    end else begin
      output_pair_enable <= {en_top_r, en_high_r, en_low_r};
    end
  end

  // Checks on the engine and registers.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The ninth bit is pending while the bus clock is still high.
  sequence s_ack_wait;
    (state_r == ST_ACK_PEND) && !scl_fall;
  endsequence

  // The bus clock then falls while the acknowledge is still pending.
  sequence s_byte_ack;
    s_ack_wait ##1 ((state_r == ST_ACK_PEND) && scl_fall && !start_det
                    && !stop_det);
  endsequence

  property p_ack_driven;
    s_byte_ack |=> sda_oe && (state_r == ST_ACK_DRV);
  endproperty
  a_ack_driven: assert property (p_ack_driven)
    else $error("No ack driven.");

  property p_write_index_step;
    reg_wr && !start_det && !stop_det |=> index_r == $past(index_r) + 8'h01;
  endproperty
  a_write_index_step: assert property (p_write_index_step)
    else $error("Write index did not advance.");

  property p_read_addr_phase;
    byte_done && phase_r == PH_ADDR && addr_hit && rx_byte[0] && !start_det
      && !stop_det |=> phase_r == PH_TX_COUNT && state_r == ST_ACK_PEND;
  endproperty
  a_read_addr_phase: assert property (p_read_addr_phase)
    else $error("Read address not acknowledged.");

  property p_count_first;
    state_r == ST_ACK_DRV && scl_fall && rw_r && phase_r == PH_TX_COUNT
      && !start_det && !stop_det |=> shift_r == {3'h0, read_count_r};
  endproperty
  a_count_first: assert property (p_count_first)
    else $error("Byte count not sent first.");

  property p_addr_mid_mid;
    $rose(latched_r) && $past(pins_lvl[5:2]) == {SCB_STRAP_MID, SCB_STRAP_MID}
      |-> dev_addr_r == SCB_ADDR_MM;
  endproperty
  a_addr_mid_mid: assert property (p_addr_mid_mid)
    else $error("Strapped address wrong.");

  property p_foreign_ignored;
    byte_done && phase_r == PH_ADDR && !addr_hit && !start_det && !stop_det
      |=> state_r == ST_IDLE ##1 !sda_oe;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("Foreign address answered.");

  property p_mode_held;
    latched_r |=> $stable(pll_mode_r) && $stable(freq_r);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("Strap readback changed.");

  property p_enable_write;
    reg_wr && index_r == SCB_IDX_OUTPUT_ENABLE_LOW
      |=> ##1 output_pair_enable[7:0] == $past(rx_byte, 2);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Low enables not updated.");

  property p_top_enable_write;
    reg_wr && index_r == SCB_IDX_PLL_MODE_FREQ_STATUS
      |=> en_top_r == $past(rx_byte[5:3]) && $stable(pll_mode_r);
  endproperty
  a_top_enable_write: assert property (p_top_enable_write)
    else $error("Top enables not updated.");

  property p_count_write;
    reg_wr && index_r == SCB_IDX_READ_COUNT
      |=> read_count_r == $past(rx_byte[4:0]);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("Read count not updated.");

endmodule : scb_target
`default_nettype wire

/* File: scb_pkg.sv */
// Package with register map, reset values and encodings of the clock buffer.
package scb_pkg;

  // Register indices reached through the indexed block protocol.
  localparam logic [7:0] SCB_IDX_PLL_MODE_FREQ_STATUS = 8'h00;
  localparam logic [7:0] SCB_IDX_OUTPUT_ENABLE_LOW    = 8'h01;
  localparam logic [7:0] SCB_IDX_OUTPUT_ENABLE_HIGH   = 8'h02;
  localparam logic [7:0] SCB_IDX_READ_COUNT           = 8'h07;

  // Field positions inside the status byte.
  localparam int SCB_POS_PLL_MODE_LSB = 6;
  localparam int SCB_POS_TOP_EN_LSB   = 3;
  localparam int SCB_POS_FREQ         = 0;

  // Values after reset.
  localparam logic [7:0] SCB_RST_ENABLE_BYTE = 8'hFF;
  localparam logic [2:0] SCB_RST_TOP_ENABLE  = 3'h7;
  localparam logic [4:0] SCB_RST_READ_COUNT  = 5'h08;

  // Three-level strap codes presented on each two-bit strap input.
  localparam logic [1:0] SCB_STRAP_LOW  = 2'h0;
  localparam logic [1:0] SCB_STRAP_MID  = 2'h1;
  localparam logic [1:0] SCB_STRAP_HIGH = 2'h3;

  // Write-address bytes, indexed as {upper strap, lower strap} levels.
  localparam logic [7:0] SCB_ADDR_LL = 8'hD8;
  localparam logic [7:0] SCB_ADDR_LM = 8'hDA;
  localparam logic [7:0] SCB_ADDR_LH = 8'hDE;
  localparam logic [7:0] SCB_ADDR_ML = 8'hC2;
  localparam logic [7:0] SCB_ADDR_MM = 8'hC4;
  localparam logic [7:0] SCB_ADDR_MH = 8'hC6;
  localparam logic [7:0] SCB_ADDR_HL = 8'hCA;
  localparam logic [7:0] SCB_ADDR_HM = 8'hCC;
  localparam logic [7:0] SCB_ADDR_HH = 8'hCE;

  // Readback codes of the PLL mode for each bandwidth strap level.
  localparam logic [1:0] SCB_MODE_LOW_BW  = 2'h0;
  localparam logic [1:0] SCB_MODE_BYPASS  = 2'h1;
  localparam logic [1:0] SCB_MODE_HIGH_BW = 2'h3;

  // Cycles after reset release before the straps are captured.
  localparam logic [2:0] SCB_STRAP_SETTLE_CYC = 3'h4;

  // Protocol engine states and transaction phases.
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK_PEND, ST_ACK_DRV, ST_TX, ST_TX_ACK, ST_TX_NEXT
  } scb_state_type;

  typedef enum logic [2:0] {
    PH_ADDR, PH_INDEX, PH_COUNT, PH_DATA, PH_TX_COUNT, PH_TX_DATA
  } scb_phase_type;

endpackage : scb_pkg

/* File: scb_pin_sampler.sv */
// Three-stage pin sampler; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module scb_pin_sampler #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Asynchronous pins and their filtered levels.
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level
);

  // Refuses, at elaboration, a width that leaves no bit to sample.
  if (W < 1) begin : g_width_check
    $error("scb_pin_sampler needs at least one bit.");
  end

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] level_nxt;

  // A bit follows stage three only where stages two and three agree.
  assign level_nxt = ((ff2_r ~^ ff3_r) & ff3_r) | ((ff2_r ^ ff3_r) & level);

  // Synchroniser chain; the first stage feeds only the second.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      level <= RST_VAL;
    end else begin
      ff1_r <= pin_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      level <= level_nxt;
    end
  end

endmodule : scb_pin_sampler
`default_nettype wire

/* File: scb_host_model.sv */
// Behavioural bus host issuing indexed block writes and block reads.
`timescale 1ns/1ps
`default_nettype none
module scb_host_model #(
  parameter int HALF = 24,
  parameter int QTR  = 4
) (
  // Bench clock.
  input  wire logic clk,
  // Bus wires; the host only pulls data low or lets it float high.
  output var  logic scl,
  output var  logic sda_pull,
  input  wire logic sda_line
);
  // Both wires float high while the bus is idle.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Waits whole cycles and then steps just past the edge.
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_pull = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_pull = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(QTR);
  endtask : start_cond

  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    sda_pull = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_pull = 1'b0;
    hold(HALF);
  endtask : stop_cond

  // One bit slot; the wire is sampled at the end of the high phase.
  task automatic bit_slot(input logic drv, output logic seen);
    sda_pull = ~drv;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    seen = sda_line;
    scl = 1'b0;
    hold(QTR);
  endtask : bit_slot

  // Sends a byte most significant bit first and returns the acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // Receives a byte; the last one is answered with a not-acknowledge.
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(last, s);
  endtask : get_byte

  // Address, index, count, then the data bytes; gives up if the address is refused.
  task automatic block_write(input logic [7:0] adr, input logic [7:0] idx,
                             input logic [7:0] d[$], output logic ok);
    logic a;
    start_cond();
    put_byte(adr, a);
    ok = a;
    if (a) begin
      put_byte(idx, a);
      ok &= a;
      put_byte(8'(d.size()), a);
      ok &= a;
      foreach (d[k]) begin
        put_byte(d[k], a);
        ok &= a;
      end
    end
    stop_cond();
  endtask : block_write

  // Index set, repeated start, then count byte and n register bytes.
  task automatic block_read(input logic [7:0] adr, input logic [7:0] idx,
                            input int n, output logic [7:0] q[$],
                            output logic ok);
    logic       a;
    logic [7:0] b;
    q = {};
    start_cond();
    put_byte(adr, a);
    ok = a;
    if (a) begin
      put_byte(idx, a);
      ok &= a;
      start_cond();
      put_byte(adr | 8'h01, a);
      ok &= a;
      for (int k = 0; k <= n; k++) begin
        get_byte(k == n, b);
        q.push_back(b);
      end
    end
    stop_cond();
  endtask : block_read
endmodule : scb_host_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the bus target with its strap and enable bytes.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Rows: address straps, bandwidth strap, frequency strap, write address.
  localparam logic [14:0] ROWS [9] = '{
    {4'h0, 2'h0, 1'h0, 8'hD8}, {4'h1, 2'h1, 1'h1, 8'hDA},
    {4'h3, 2'h3, 1'h0, 8'hDE}, {4'h4, 2'h0, 1'h1, 8'hC2},
    {4'h5, 2'h1, 1'h0, 8'hC4}, {4'h7, 2'h3, 1'h1, 8'hC6},
    {4'hC, 2'h0, 1'h0, 8'hCA}, {4'hD, 2'h1, 1'h1, 8'hCC},
    {4'hF, 2'h3, 1'h0, 8'hCE}};
  localparam int LIMIT = 80000;

  // Design pins and bench state.
  logic        clk;
  logic        sys_rst;
  logic        scl;
  logic        host_pull;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic [3:0]  straps;
  logic [1:0]  pll_strap;
  logic        freq_strap;
  logic [18:0] output_pair_enable;
  logic [7:0]  q[$];
  logic [7:0]  d[$];
  logic        ok;
  int          failures;
  int          n_tests;
  int          cycles;

  // The data wire is pulled up and low whenever either party pulls it.
  assign sda_line = (host_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  always #4 clk = ~clk;

  scb_target dut (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .scl_in             (scl),
    .sda_in             (sda_line),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .bus_address_straps (straps),
    .pll_bandwidth_strap(pll_strap),
    .freq_select_strap  (freq_strap),
    .output_pair_enable (output_pair_enable)
  );

  scb_host_model host (
    .clk     (clk),
    .scl     (scl),
    .sda_pull(host_pull),
    .sda_line(sda_line)
  );

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic [18:0] got, input logic [18:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : check

  // Applies the straps of a row and pulses reset for two cycles.
  task automatic do_reset(input logic [14:0] row);
    @(posedge clk);
    #1;
    {straps, pll_strap, freq_strap} = row[14:8];
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  // Main sequence: strap table first, then the hand-written cases.
  initial begin
    clk        = 1'b0;
    sys_rst    = 1'b1;
    straps     = 4'h0;
    pll_strap  = 2'h0;
    freq_strap = 1'b0;
    failures   = 0;
    n_tests    = 0;
    cycles     = 0;
    foreach (ROWS[r]) begin
      do_reset(ROWS[r]);
      host.block_read(ROWS[r][7:0], 8'h00, 1, q, ok);
      check(19'(ok), 19'h1, "address ack");
      check(19'(q[0]), 19'h08, "count byte");
      check(19'(q[1]), {11'h0, ROWS[r][10:9], 3'h7, 2'h0, ROWS[r][8]},
            "status");
      d = {8'h00};
      host.block_write(ROWS[(r + 1) % 9][7:0], 8'h01, d, ok);
      check(19'(ok), 19'h0, "foreign ack");
      check(output_pair_enable, 19'h7FFFF, "foreign write");
      $display("row %0d done", r);
    end
    // Straps stay high/high: mode 11, frequency 0, address CE.
    d = {8'h17, 8'h0F, 8'hA5};
    host.block_write(8'hCE, 8'h00, d, ok);
    check(19'(ok), 19'h1, "write acks");
    check(output_pair_enable, 19'h2A50F, "enables");
    host.block_read(8'hCE, 8'h00, 3, q, ok);
    check(19'(q[1]), 19'hD0, "read-only bits");
    check(19'(q[2]), 19'h0F, "low enables");
    check(19'(q[3]), 19'hA5, "high enables");
    $display("write and readback done");
    d = {8'h03};
    host.block_write(8'hCE, 8'h07, d, ok);
    host.block_read(8'hCE, 8'h07, 1, q, ok);
    check(19'(q[0]), 19'h03, "new count");
    check(19'(q[1]), 19'h03, "count register");
    $display("read count done");
    do_reset(ROWS[0]);
    check(output_pair_enable, 19'h7FFFF, "second reset");
    check(19'(sda_oe), 19'h0, "bus released");
    $display("second reset done");
    conclude();
  end
endmodule : tb
`default_nettype wire
